// file: rtl/mcs_pkg.sv
// package of constants for the mixed clock state sampler
package mcs_pkg;
	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int NUM_CLK   = 5;   // probe clock channels
	localparam int POD_W     = 16;  // data lines of one pod
	localparam int HALF_W    = 8;   // one captured byte
	localparam int QUAL_W    = 3;   // one qualifier code
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [4:0] OFS_CTRL   = 5'h00;
	localparam logic [4:0] OFS_SQUAL  = 5'h04;  // secondary arrangement
	localparam logic [4:0] OFS_PQUAL  = 5'h08;  // primary arrangement
	localparam logic [4:0] OFS_PAT    = 5'h0c;  // trigger pattern
	localparam logic [4:0] OFS_STATUS = 5'h10;
	localparam logic [4:0] OFS_STATE  = 5'h14;  // read clears valid
	localparam logic [4:0] OFS_COUNT  = 5'h18;  // occurrence count
	// ------------------------------------------------------------
	// control and status bit positions
	// ------------------------------------------------------------
	localparam int CTRL_EN    = 0;  // sampling enable
	localparam int CTRL_SHORT = 1;  // clock period below limit
	localparam int CTRL_COUNT = 2;  // occurrence counting request
	localparam int CTRL_PRE   = 3;  // prestore request
	localparam int STAT_VALID = 0;  // new combined state waiting
	localparam int STAT_SERR  = 1;  // secondary has no edge
	localparam int STAT_PERR  = 2;  // primary has no edge
	localparam int STAT_TRIG  = 3;  // trigger pattern seen
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [3:0]  RST_CTRL = 4'h0;
	localparam logic [14:0] RST_QUAL = 15'h0000;
	localparam logic [15:0] RST_PAT  = 16'h0000;
	// ------------------------------------------------------------
	// qualifier codes, one per clock channel
	// ------------------------------------------------------------
	localparam logic [2:0] Q_OFF  = 3'h0;
	localparam logic [2:0] Q_FALL = 3'h1;
	localparam logic [2:0] Q_RISE = 3'h2;
	localparam logic [2:0] Q_BOTH = 3'h3;
	localparam logic [2:0] Q_HIGH = 3'h4;
	localparam logic [2:0] Q_LOW  = 3'h5;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int PERIOD_LIMIT_NS = 60;  // boundary of the period option
endpackage : mcs_pkg

// file: rtl/mcs_sampler.sv
// mixed clock state sampler: link capture, crossings and register slave
// Summary of operation
// - low byte on secondary, high on primary
// - wait secondary first, then primary
// - primary after secondary latches upper byte
// - all sixteen pod lines are used
// - identical arrangements: next event takes high
// - short period disables occurrence counting
// - short period forces prestore off
// - long period filters short clock glitches
// - long period gives tighter trigger timing
// - six qualifiers per clock input
// - edges ORed, levels ORed, then ANDed
`timescale 1ns/100ps
module mcs_sampler #(
	parameter int NCLK = mcs_pkg::NUM_CLK
) (
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	input  wire logic        LINK_CLK_I,
	input  wire logic [4:0]  PROBE_CLK_I,
	input  wire logic [15:0] POD_I,
	input  wire logic [4:0]  ADDRESS_I,
	input  wire logic        READ_I,
	input  wire logic        WRITE_I,
	input  wire logic [31:0] WRITEDATA_I,
	input  wire logic [3:0]  BYTEENABLE_I,
	output logic      [31:0] READDATA_O,
	output logic             WAITREQUEST_O,
	output logic             TRIG_O
);
	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (NCLK != mcs_pkg::NUM_CLK) begin : g_chk
		$error("NCLK must equal the five probe clock channels");
	end

	typedef enum logic {MCS_WAIT_SEC, MCS_WAIT_PRI} mcs_state_t;

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// arrangement fires: any chosen edge and any chosen level
	function automatic logic fire(input logic [14:0] q, input logic [4:0] cur,
		input logic [4:0] prv);
		logic e;
		logic l;
		logic any_l;
		logic [2:0] c;
		e = 1'b0;
		l = 1'b0;
		any_l = 1'b0;
		for (int i = 0; i < mcs_pkg::NUM_CLK; i++) begin
			c = q[i*mcs_pkg::QUAL_W +: mcs_pkg::QUAL_W];
			if ((c == mcs_pkg::Q_FALL || c == mcs_pkg::Q_BOTH) && prv[i] && !cur[i]) begin
				e = 1'b1;
			end
			if ((c == mcs_pkg::Q_RISE || c == mcs_pkg::Q_BOTH) && !prv[i] && cur[i]) begin
				e = 1'b1;
			end
			if (c == mcs_pkg::Q_HIGH) begin
				any_l = 1'b1;
				l = l | cur[i];
			end
			if (c == mcs_pkg::Q_LOW) begin
				any_l = 1'b1;
				l = l | !cur[i];
			end
		end
		// no level chosen means levels do not restrict
		return e && (l || !any_l);
	endfunction : fire

	// true when the arrangement holds at least one edge qualifier
	function automatic logic has_edge(input logic [14:0] q);
		logic r;
		logic [2:0] c;
		r = 1'b0;
		for (int i = 0; i < mcs_pkg::NUM_CLK; i++) begin
			c = q[i*mcs_pkg::QUAL_W +: mcs_pkg::QUAL_W];
			if (c == mcs_pkg::Q_FALL || c == mcs_pkg::Q_RISE || c == mcs_pkg::Q_BOTH) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction : has_edge

	// byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// ------------------------------------------------------------
	// system domain registers
	// ------------------------------------------------------------
	logic [3:0]  ctrl;        // raw control bits
	logic [14:0] squal;       // secondary arrangement
	logic [14:0] pqual;       // primary arrangement
	logic [15:0] pat;         // trigger pattern
	logic [15:0] state_q;     // last combined state
	logic        valid;       // state waiting to be read
	logic        trig_seen;   // trigger pattern met since control write
	logic [31:0] count;       // occurrence count
	logic        acc;         // request accepted this edge
	logic        wr_acc;      // accepted write
	logic        cfg_dirty;   // config changed, not yet sent
	logic        cfg_req;     // config toggle toward the link
	logic [47:0] cfg_shadow;  // config frozen while in flight: {en, short, pat, pqual, squal}
	logic        cfg_ack;     // config toggle already taken, link side
	logic        st_req;      // state toggle toward the system, link side
	logic        cak_a;       // config ack synchroniser
	logic        cak_b;
	logic        st_a;        // state toggle synchroniser
	logic        st_b;
	logic        st_c;        // last seen, edge reference
	logic        short_p;     // effective short period
	logic        cnt_act;     // effective counting
	logic        pre_act;     // effective prestore
	logic        new_st;      // combined state arrived
	logic        new_match;   // arrived state equals pattern
	logic [15:0] st_word;     // link-held combined state

	assign short_p   = ctrl[mcs_pkg::CTRL_SHORT];
	assign cnt_act   = ctrl[mcs_pkg::CTRL_COUNT] & ~short_p;
	assign pre_act   = ctrl[mcs_pkg::CTRL_PRE] & ~short_p;
	assign acc       = (READ_I | WRITE_I) & ~WAITREQUEST_O;
	assign wr_acc    = WRITE_I & ~WAITREQUEST_O;
	assign new_st    = st_b ^ st_c;
	assign new_match = (st_word == pat);

	// one wait cycle, then a single accepting cycle
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			WAITREQUEST_O <= 1'b1;
		end else if ((READ_I | WRITE_I) & WAITREQUEST_O) begin
			WAITREQUEST_O <= 1'b0;
		end else begin
			WAITREQUEST_O <= 1'b1;
		end
	end

	// read data is prepared in the wait cycle and stands when accepted
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			READDATA_O <= 32'h0000_0000;
		end else if (READ_I & WAITREQUEST_O) begin
			unique case (ADDRESS_I)
				mcs_pkg::OFS_CTRL:   READDATA_O <= {28'h0, pre_act, cnt_act, short_p,
					ctrl[mcs_pkg::CTRL_EN]};
				mcs_pkg::OFS_SQUAL:  READDATA_O <= {17'h0, squal};
				mcs_pkg::OFS_PQUAL:  READDATA_O <= {17'h0, pqual};
				mcs_pkg::OFS_PAT:    READDATA_O <= {16'h0, pat};
				mcs_pkg::OFS_STATUS: READDATA_O <= {28'h0, trig_seen, ~has_edge(pqual),
					~has_edge(squal), valid};
				mcs_pkg::OFS_STATE:  READDATA_O <= {16'h0, state_q};
				mcs_pkg::OFS_COUNT:  READDATA_O <= count;
				default:             READDATA_O <= 32'h0000_0000;  // unmapped
			endcase
		end
	end

	// configuration registers
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			ctrl  <= mcs_pkg::RST_CTRL;
			squal <= mcs_pkg::RST_QUAL;
			pqual <= mcs_pkg::RST_QUAL;
			pat   <= mcs_pkg::RST_PAT;
		end else if (wr_acc) begin
			unique case (ADDRESS_I)
				mcs_pkg::OFS_CTRL:  ctrl  <= 4'(merge({28'h0, ctrl}, WRITEDATA_I, BYTEENABLE_I));
				mcs_pkg::OFS_SQUAL: squal <= 15'(merge({17'h0, squal}, WRITEDATA_I, BYTEENABLE_I));
				mcs_pkg::OFS_PQUAL: pqual <= 15'(merge({17'h0, pqual}, WRITEDATA_I, BYTEENABLE_I));
				mcs_pkg::OFS_PAT:   pat   <= 16'(merge({16'h0, pat}, WRITEDATA_I, BYTEENABLE_I));
				default:            ;  // read-only or unmapped: ignored
			endcase
		end
	end

	// config handshake: shadow only moves while the link has acknowledged
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			cfg_dirty  <= 1'b1;
			cfg_req    <= 1'b0;
			cfg_shadow <= 48'h0;
		end else begin
			if (cfg_req == cak_b && cfg_dirty && !wr_acc) begin
				cfg_shadow <= {ctrl[mcs_pkg::CTRL_EN], short_p, pat, pqual, squal};
				cfg_req    <= ~cfg_req;
				cfg_dirty  <= 1'b0;
			end else if (wr_acc) begin
				cfg_dirty  <= 1'b1;
			end
		end
	end

	// synchronisers toward the system clock
	always_ff @(posedge CLK_I) begin
		cak_a <= cfg_ack;
		cak_b <= cak_a;
		st_a  <= st_req;
		st_b  <= st_a;
		if (RST_I) begin
			st_c <= 1'b0;
		end else begin
			st_c <= st_b;
		end
	end

	// combined state store; set wins over the read that clears
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			state_q   <= 16'h0000;
			valid     <= 1'b0;
			trig_seen <= 1'b0;
		end else begin
			if (acc && READ_I && ADDRESS_I == mcs_pkg::OFS_STATE) begin
				valid <= 1'b0;
			end
			if (wr_acc && ADDRESS_I == mcs_pkg::OFS_CTRL) begin
				trig_seen <= 1'b0;
			end
			if (new_st) begin
				if (new_match) begin
					trig_seen <= 1'b1;
				end
				// without prestore, states before the trigger are not kept
				if (pre_act || trig_seen || new_match) begin
					state_q <= st_word;
					valid   <= 1'b1;
				end
			end
		end
	end

	// occurrence count of the trigger pattern
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			count <= 32'h0000_0000;
		end else if (wr_acc && ADDRESS_I == mcs_pkg::OFS_CTRL) begin
			count <= 32'h0000_0000;
		end else if (new_st && new_match && cnt_act) begin
			count <= count + 32'h0000_0001;
		end
	end

	// ------------------------------------------------------------
	// link domain
	// ------------------------------------------------------------
	logic        lrst_a;     // reset synchroniser
	logic        lrst;
	logic [4:0]  clk_a;      // probe clock synchroniser
	logic [4:0]  clk_b;
	logic [4:0]  clk_c;      // one more sample for the glitch filter
	logic [4:0]  lvl;        // accepted clock levels
	logic [4:0]  lvl_p;      // previous accepted levels
	logic [15:0] pod_a;      // data synchroniser
	logic [15:0] pod_b;
	logic [15:0] pod_c;      // aligned with lvl
	logic        crq_a;      // config toggle synchroniser
	logic        crq_b;
	logic [47:0] lcfg;       // link copy of config
	logic        sak_a;      // state ack synchroniser
	logic        sak_b;
	logic [7:0]  low;        // low byte from the secondary capture
	logic        t1;         // extra trigger stage for short period
	logic        sfire;
	logic        pfire;
	logic        hit;        // pair completed and equals pattern
	mcs_state_t  lst;

	assign sfire = fire(lcfg[14:0], lvl, lvl_p);
	assign pfire = fire(lcfg[29:15], lvl, lvl_p);
	assign hit   = (lst == MCS_WAIT_PRI) && pfire && ({pod_c[15:8], low} == lcfg[45:30]);

	// reset release and input synchronisers on the link clock
	always_ff @(posedge LINK_CLK_I) begin
		lrst_a <= RST_I;
		lrst   <= lrst_a;
		clk_a  <= PROBE_CLK_I;
		clk_b  <= clk_a;
		clk_c  <= clk_b;
		pod_a  <= POD_I;
		pod_b  <= pod_a;
		pod_c  <= pod_b;
		crq_a  <= cfg_req;
		crq_b  <= crq_a;
		sak_a  <= st_c;
		sak_b  <= sak_a;
	end

	// clock level tracking; long period needs two equal samples
	always_ff @(posedge LINK_CLK_I) begin
		if (lrst) begin
			lvl   <= 5'h00;
			lvl_p <= 5'h00;
		end else begin
			lvl_p <= lvl;
			for (int i = 0; i < mcs_pkg::NUM_CLK; i++) begin
				if (lcfg[46] || clk_b[i] == clk_c[i]) begin
					lvl[i] <= clk_b[i];
				end
			end
		end
	end

	// config load on each new toggle
	always_ff @(posedge LINK_CLK_I) begin
		if (lrst) begin
			cfg_ack <= 1'b0;
			lcfg    <= 48'h0;
		end else if (crq_b != cfg_ack) begin
			cfg_ack <= crq_b;
			lcfg    <= cfg_shadow;
		end
	end

	// pair capture: secondary gives low byte, primary then gives high
	always_ff @(posedge LINK_CLK_I) begin
		if (lrst) begin
			// toggle returns to zero in step with the system side reset
			lst     <= MCS_WAIT_SEC;
			low     <= 8'h00;
			st_req  <= 1'b0;
			st_word <= 16'h0000;
		end else if (!lcfg[47]) begin
			// disabled: toggle untouched so no false state reaches the system
			lst     <= MCS_WAIT_SEC;
			low     <= 8'h00;
		end else begin
			unique case (lst)
				MCS_WAIT_SEC: begin
					// only this arrangement is watched here
					if (sfire) begin
						low <= pod_c[7:0];
						lst <= MCS_WAIT_PRI;
					end
				end
				MCS_WAIT_PRI: begin
					// the event that took the low byte cannot also take the high
					if (pfire) begin
						lst <= MCS_WAIT_SEC;
						if (st_req == sak_b) begin
							st_word <= {pod_c[15:8], low};
							st_req  <= ~st_req;
						end
					end
				end
			endcase
		end
	end

	// trigger out: long period drives it at the capture edge
	always_ff @(posedge LINK_CLK_I) begin
		if (lrst) begin
			t1     <= 1'b0;
			TRIG_O <= 1'b0;
		end else begin
			t1     <= hit & lcfg[47];
			TRIG_O <= lcfg[46] ? t1 : (hit & lcfg[47]);
		end
	end
endmodule : mcs_sampler

// file: test/mcs_sampler_sva.sv
// checker: bus handshake, control readback and trigger pulse of the sampler
`timescale 1ns/100ps
module mcs_sampler_sva #(
	parameter int NCLK = mcs_pkg::NUM_CLK
) (
	input wire logic        CLK_I,
	input wire logic        RST_I,
	input wire logic        LINK_CLK_I,
	input wire logic [4:0]  ADDRESS_I,
	input wire logic        READ_I,
	input wire logic        WRITE_I,
	input wire logic [31:0] READDATA_O,
	input wire logic        WAITREQUEST_O,
	input wire logic        TRIG_O
);
	// ------------------------------------------------------------
	// bus steps
	// ------------------------------------------------------------
	wire logic rd_acc = READ_I && !WAITREQUEST_O;  // read taken at this edge
	sequence s_req_seen;
		(READ_I || WRITE_I) && WAITREQUEST_O;
	endsequence
	sequence s_one_answer;
		!WAITREQUEST_O ##1 WAITREQUEST_O;
	endsequence
	chk_req_answer: assert property (@(posedge CLK_I) disable iff (RST_I)
		s_req_seen |=> s_one_answer) else $error("request not answered in one cycle");
	chk_no_spurious: assert property (@(posedge CLK_I) disable iff (RST_I)
		$fell(WAITREQUEST_O) |-> $past(READ_I || WRITE_I)) else $error("answer without request");
	chk_wait_idle: assert property (@(posedge CLK_I) disable iff (RST_I)
		!(READ_I || WRITE_I) |=> WAITREQUEST_O) else $error("waitrequest low while idle");
	// effective request bits must read zero once the short period is set
	chk_short_count: assert property (@(posedge CLK_I) disable iff (RST_I)
		rd_acc && ADDRESS_I == mcs_pkg::OFS_CTRL && READDATA_O[1] |-> !READDATA_O[2])
		else $error("count request reads set in short period");
	chk_short_pre: assert property (@(posedge CLK_I) disable iff (RST_I)
		rd_acc && ADDRESS_I == mcs_pkg::OFS_CTRL && READDATA_O[1] |-> !READDATA_O[3])
		else $error("prestore reads set in short period");
	chk_unmapped_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
		rd_acc && ADDRESS_I > mcs_pkg::OFS_COUNT |-> READDATA_O == 32'h0)
		else $error("unmapped read not zero");
	// ------------------------------------------------------------
	// link side
	// ------------------------------------------------------------
	chk_trig_pulse: assert property (@(posedge LINK_CLK_I) disable iff (RST_I)
		$rose(TRIG_O) |=> !TRIG_O) else $error("trigger longer than one link cycle");
	// link reset passes two sync flops, so only a long reset is judged
	chk_trig_reset: assert property (@(posedge LINK_CLK_I)
		RST_I [*5] |-> !TRIG_O) else $error("trigger high in reset");
endmodule : mcs_sampler_sva

// file: test/mcs_target.sv
// far-side model: target system driving probe clocks and pod lines
`timescale 1ns/100ps
module mcs_target (
	output logic [4:0]  PROBE_CLK_O,
	output logic [15:0] POD_O
);
	// idle: edges low, channel 2 high as the level qualifier
	initial begin
		PROBE_CLK_O = 5'h04;
		POD_O       = 16'h0000;
	end
	// one rising edge on channel ch, data held on both sides of it
	task automatic pulse(input int ch, input logic [15:0] w, input int hold);
		POD_O           = w;
		#(hold);
		PROBE_CLK_O[ch] = 1'b1;
		#(hold);
		PROBE_CLK_O[ch] = 1'b0;
		POD_O           = ~w;  // hold over: stale data must not pass as good
		#(hold);
	endtask : pulse
	// low byte valid on the secondary edge, high byte on the primary edge
	task automatic pair(input logic [15:0] w, input int hold);
		pulse(0, {~w[15:8], w[7:0]}, hold);
		pulse(1, {w[15:8], ~w[7:0]}, hold);
	endtask : pair
	// sets the level qualifier channel
	task automatic level(input logic v);
		PROBE_CLK_O[2] = v;
		#(300);
	endtask : level
	// a runt pulse shorter than one link sample, with junk data
	task automatic glitch;
		POD_O          = 16'hee11;
		#(40);
		PROBE_CLK_O[0] = 1'b1;
		#(10);
		PROBE_CLK_O[0] = 1'b0;
		#(300);
	endtask : glitch
endmodule : mcs_target

// file: test/tb.sv
// testbench: register bus scenarios with a target model on the probe side
`timescale 1ns/100ps
module tb;
	logic        clk   = 1'b0;  // system clock
	logic        lclk  = 1'b0;  // link clock, unrelated phase
	logic        rst   = 1'b1;
	logic [4:0]  pclk;          // probe clocks from the target
	logic [15:0] pod;
	logic [4:0]  addr  = 5'h00;
	logic        rd_en = 1'b0;
	logic        wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  be    = 4'hf;
	logic [31:0] rdata;
	logic        waitreq;
	logic        trig;
	int          failures = 0;
	int          n_tests  = 0;
	int          n_trig   = 0;  // trigger pulses seen
	int          seed     = 5617;
	logic [31:0] exp_q[$];      // expected read data, oldest first
	logic [31:0] msk_q[$];      // bits compared, zero for polls
	logic [31:0] q;             // last read data
	logic [15:0] p;             // trigger pattern
	logic [15:0] r;             // random state
	always #5 clk = ~clk;
	always #7.5 lclk = ~lclk;
	mcs_sampler i_mcs_sampler (.CLK_I(clk), .RST_I(rst), .LINK_CLK_I(lclk), .PROBE_CLK_I(pclk),
		.POD_I(pod), .ADDRESS_I(addr), .READ_I(rd_en), .WRITE_I(wr_en), .WRITEDATA_I(wdata),
		.BYTEENABLE_I(be), .READDATA_O(rdata), .WAITREQUEST_O(waitreq), .TRIG_O(trig));
	mcs_target i_mcs_target (.PROBE_CLK_O(pclk), .POD_O(pod));
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			failures++;
			$display("MISMATCH %0t: saw %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic final_report;
		if (failures == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	task automatic hang;
		failures++;
		$display("MISMATCH %0t: wait ran out", $time);
		final_report();
	endtask : hang
	// one bus cycle: held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] b);
		int n;
		n = 0;
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		be    <= b;
		wr_en <= w;
		rd_en <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 100);
		q = rdata;
		if (n >= 100)
			hang();
		rd_en <= 1'b0;
		wr_en <= 1'b0;
	endtask : bus
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
		bus(1'b1, a, d, b);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		bus(1'b0, a, 32'h0, 4'hf);
	endtask : rd
	// waits for a new combined state, bounded
	task automatic poll;
		for (int i = 0; i < 60; i++) begin
			rd(mcs_pkg::OFS_STATUS, 32'h0, 32'h0);
			if (q[0] === 1'b1)
				return;
		end
		hang();
	endtask : poll
	// takes the oldest note whenever a read is accepted
	always @(posedge clk) begin
		if (rd_en === 1'b1 && waitreq === 1'b0) begin
			if (msk_q[0] !== 32'h0)
				check(rdata & msk_q[0], exp_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end
	always @(posedge lclk) begin
		if (trig === 1'b1)
			n_trig++;
	end
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(mcs_pkg::OFS_CTRL, 32'h0);
		rd(mcs_pkg::OFS_PQUAL, 32'h0);
		rd(mcs_pkg::OFS_PAT, 32'h0);
		rd(mcs_pkg::OFS_STATUS, 32'h6);
		wr(5'h1c, 32'hffffffff, 4'hf);
		rd(5'h1c, 32'h0);
		p = 16'($random(seed));
		wr(mcs_pkg::OFS_PAT, {16'h0, p[15:8], ~p[7:0]}, 4'hf);
		wr(mcs_pkg::OFS_PAT, {24'hffffff, p[7:0]}, 4'h1);
		rd(mcs_pkg::OFS_PAT, {16'h0, p});
		wr(mcs_pkg::OFS_SQUAL, 32'h0102, 4'hf);
		wr(mcs_pkg::OFS_PQUAL, 32'h0010, 4'hf);
		wr(mcs_pkg::OFS_CTRL, 32'h5, 4'hf);
		rd(mcs_pkg::OFS_STATUS, 32'h0);
		repeat (12) @(posedge lclk);
		i_mcs_target.pair(p, 300);
		poll();
		rd(mcs_pkg::OFS_STATUS, 32'h9);
		rd(mcs_pkg::OFS_STATE, {16'h0, p});
		rd(mcs_pkg::OFS_STATUS, 32'h8);
		rd(mcs_pkg::OFS_COUNT, 32'h1);
		// stray edges: secondary without its level, primary before secondary
		r = 16'($random(seed));
		i_mcs_target.level(1'b0);
		i_mcs_target.pulse(0, ~r, 300);
		i_mcs_target.level(1'b1);
		i_mcs_target.pulse(1, ~r, 300);
		i_mcs_target.pair(r, 90);
		poll();
		rd(mcs_pkg::OFS_STATE, {16'h0, r});
		r = 16'($random(seed));
		i_mcs_target.glitch();
		i_mcs_target.pair(r, 300);
		poll();
		rd(mcs_pkg::OFS_STATE, {16'h0, r});
		wr(mcs_pkg::OFS_PQUAL, 32'h0102, 4'hf);
		repeat (12) @(posedge lclk);
		r = 16'($random(seed));
		i_mcs_target.pulse(0, {~r[15:8], r[7:0]}, 90);
		i_mcs_target.pulse(0, {r[15:8], ~r[7:0]}, 90);
		poll();
		rd(mcs_pkg::OFS_STATE, {16'h0, r});
		// fast target: short period drops counting and prestore
		wr(mcs_pkg::OFS_PQUAL, 32'h0010, 4'hf);
		wr(mcs_pkg::OFS_CTRL, 32'hf, 4'hf);
		repeat (12) @(posedge lclk);
		rd(mcs_pkg::OFS_CTRL, 32'h3);
		i_mcs_target.pair(p, 90);
		poll();
		rd(mcs_pkg::OFS_STATE, {16'h0, p});
		rd(mcs_pkg::OFS_COUNT, 32'h0);
		check(n_trig, 2);
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(mcs_pkg::OFS_CTRL, 32'h0);
		rd(mcs_pkg::OFS_STATUS, 32'h6);
		@(posedge clk);
		final_report();
	end
endmodule : tb
bind mcs_sampler mcs_sampler_sva #(.NCLK(NCLK)) i_mcs_sampler_sva (.CLK_I(CLK_I), .RST_I(RST_I),
	.LINK_CLK_I(LINK_CLK_I), .ADDRESS_I(ADDRESS_I), .READ_I(READ_I), .WRITE_I(WRITE_I),
	.READDATA_O(READDATA_O), .WAITREQUEST_O(WAITREQUEST_O), .TRIG_O(TRIG_O));
